// [common/dpsm_params.svh]
/*
 * Constants of the dual sub-cycle modulator: offsets, field positions,
 * reset values and counts. Assumes a 32-bit AXI4-Lite register port.
 */
// Operation
// [RL1] Two independent channels, each with a writable 8-bit duty register.
// [RL2] Fixed option picks two sub-cycles (7+1) or four sub-cycles (6+2).
// [RL3] Counters advance once per system clock, no prescaler, both channels.
// [RL4] Full period is 256 clocks in both modes; duty is value/256.
// [RL5] Four-sub-cycle mode: sub-cycles 0 to 3, 64 clocks each.
// [RL6] Four-sub-cycle mode: bits 7..2 base count, bits 1..0 extra count.
// [RL7] Four-sub-cycle mode: index below extra gives base+1 high, else base.
// [RL8] Two-sub-cycle mode: sub-cycles 0 and 1, 128 clocks each.
// [RL9] Two-sub-cycle mode: bits 7..1 base count, bit 0 extra count.
// [RL10] Two-sub-cycle mode: index below extra bit gives base+1 high, else base.
// [RL11] Waveform reaches pin only with modulator option and direction bit 0.
// [RL12] Output gate bit 1 passes the waveform to the pin.
// [RL13] Output gate bit 0 stops the waveform and drives the pin low.
// [RL14] Modulator option with direction bit 1 leaves the pin a plain input.
// [RL15] Software sets option and duty before opening the output gate.
// [RL16] Each sub-cycle drives high first for the high count, then low.
// [RL17] New duty takes effect at the start of the next 256-clock period.
`ifndef DPSM_PARAMS_SVH
`define DPSM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DPSM_AW 5
`define DPSM_OFF_DUTY0 5'h00
`define DPSM_OFF_DUTY1 5'h04
`define DPSM_OFF_DIR 5'h08
`define DPSM_OFF_GATE 5'h0c
`define DPSM_OFF_STAT 5'h10

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define DPSM_PIN_LSB 4
`define DPSM_DUTY_RST 8'h00
`define DPSM_DIR_RST 2'h3
`define DPSM_GATE_RST 2'h0
`define DPSM_STAT_CNT_LSB 0
`define DPSM_STAT_PIN_LSB 8
`define DPSM_STAT_WAVE_LSB 10
`define DPSM_STAT_MODE_BIT 12

// ----------------------------------------------------------------------
// Timing and bus responses
// ----------------------------------------------------------------------
`define DPSM_CNT_LAST 8'hff
`define DPSM_RESP_OKAY 2'h0
`define DPSM_RESP_SLVERR 2'h2

`endif

// [common/dpsm_pkg.sv]
/*
 * Types of the dual sub-cycle modulator.
 * Assumes the params header is compiled alongside.
 */
package dpsm_pkg;

  typedef enum logic {
    DPSM_MODE_71 = 1'b0,
    DPSM_MODE_62 = 1'b1
  } dpsm_mode_t;

  typedef enum logic {
    DPSM_W_IDLE = 1'b0,
    DPSM_W_RESP = 1'b1
  } dpsm_wst_t;

  typedef enum logic {
    DPSM_R_IDLE = 1'b0,
    DPSM_R_DATA = 1'b1
  } dpsm_rst_t;

  typedef struct packed {
    logic out;
    logic oe;
  } dpsm_pin_t;

endpackage : dpsm_pkg

// [logic/dpsm_chan.sv]
/*
 * One modulator channel: shadow duty and sub-cycle waveform.
 * Assumes a shared period counter that steps on every enabled clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_params.svh"

module dpsm_chan
  import dpsm_pkg::*;
(
  // Clock and control
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire dpsm_mode_t i_mode,
  // Period position and duty
  input wire logic [7:0] i_cnt,
  input wire logic [7:0] i_duty,
  // Waveform
  output logic o_wave
);

  logic [7:0] shadow_ff;
  logic wave_ff;
  logic [7:0] hi_len;
  logic [7:0] pos;

  // ----------------------------------------------------------------------
  // Shadow duty
  // ----------------------------------------------------------------------
  // Loading only at the period end keeps one period from mixing two duties.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shadow_ff <= `DPSM_DUTY_RST;
    end else if (i_ce && i_cnt == `DPSM_CNT_LAST) begin
      shadow_ff <= i_duty; // RL17
    end
  end

  // ----------------------------------------------------------------------
  // Sub-cycle split
  // ----------------------------------------------------------------------
  always_comb begin
    if (i_mode == DPSM_MODE_62) begin
      pos = {2'h0, i_cnt[5:0]}; // RL5
      hi_len = {2'h0, shadow_ff[7:2]} + {7'h00, i_cnt[7:6] < shadow_ff[1:0]}; // RL6 RL7
    end else begin
      pos = {1'h0, i_cnt[6:0]}; // RL8
      hi_len = {1'h0, shadow_ff[7:1]} + {7'h00, i_cnt[7] < shadow_ff[0]}; // RL9 RL10
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wave_ff <= 1'b0;
    end else if (i_ce) begin
      wave_ff <= pos < hi_len; // RL16
    end
  end

  assign o_wave = wave_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n || !i_ce);

  property p_shadow_at_end;
    $changed(shadow_ff) |-> $past(i_cnt) == `DPSM_CNT_LAST;
  endproperty
  a_shadow_at_end: assert property (p_shadow_at_end) // RL17
    else $error("Shadow duty changed inside a period.");

  property p_rise_at_start;
    $rose(wave_ff) |-> $past(pos) == 8'h00;
  endproperty
  a_rise_at_start: assert property (p_rise_at_start) // RL16
    else $error("Waveform rose away from a sub-cycle start.");

  property p_full_62;
    i_mode == DPSM_MODE_62 && shadow_ff == 8'hff && i_cnt == 8'hbf
      |=> wave_ff ##1 wave_ff ##62 wave_ff ##1 !wave_ff;
  endproperty
  a_full_62: assert property (p_full_62) // RL7
    else $error("Full duty sub-cycle lengths wrong in four-sub-cycle mode.");

  property p_one_71;
    i_mode == DPSM_MODE_71 && shadow_ff == 8'h01 && i_cnt == 8'h00 && i_ce
      |=> wave_ff ##1 !wave_ff;
  endproperty
  a_one_71: assert property (p_one_71) // RL10
    else $error("Extra pulse wrong in two-sub-cycle mode.");

  c_mode_71: cover property (i_mode == DPSM_MODE_71 && $fell(wave_ff));
  c_mode_62: cover property (i_mode == DPSM_MODE_62 && $fell(wave_ff));

endmodule : dpsm_chan
`default_nettype wire

// [logic/dpsm_top.sv]
/*
 * Dual sub-cycle modulator with AXI4-Lite registers and two shared pins.
 * Assumes one 50 MHz clock; pins come from outside and are synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_params.svh"

module dpsm_top
  import dpsm_pkg::*;
#(
  parameter dpsm_mode_t P_MODE = DPSM_MODE_62,
  parameter logic [1:0] P_PWM_SEL = 2'h3
)
(
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [`DPSM_AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // Write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // Read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [`DPSM_AW-1:0] i_araddr,
  // Read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Shared pins
  input wire logic [1:0] i_pin_in,
  output dpsm_pin_t [1:0] o_pin
);

  dpsm_wst_t wst_ff;
  dpsm_rst_t rst_ff;
  logic awready_ff;
  logic wready_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [`DPSM_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] duty_value_ch0_ff;
  logic [7:0] duty_value_ch1_ff;
  logic [1:0] dir_ff;
  logic [1:0] gate_ff;
  logic [7:0] cnt_ff;
  logic [1:0] wave;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] sync3_ff;
  logic [1:0] pin_in_ff;
  dpsm_pin_t [1:0] pin_ff;
  logic do_wr;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  assign do_wr = (wst_ff == DPSM_W_IDLE) && aw_got_ff && w_got_ff;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      awready_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (i_ce) begin
      if (i_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_got_ff <= 1'b1;
        awaddr_ff <= i_awaddr;
      end else if (wst_ff == DPSM_W_IDLE && !aw_got_ff) begin
        awready_ff <= 1'b1;
      end else if (bvalid_ff && i_bready) begin
        aw_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wready_ff <= 1'b0;
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
    end else if (i_ce) begin
      if (i_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= i_wdata;
        wstrb0_ff <= i_wstrb[0];
      end else if (wst_ff == DPSM_W_IDLE && !w_got_ff) begin
        wready_ff <= 1'b1;
      end else if (bvalid_ff && i_bready) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wst_ff <= DPSM_W_IDLE;
      bvalid_ff <= 1'b0;
      bresp_ff <= `DPSM_RESP_OKAY;
    end else if (i_ce) begin
      case (wst_ff)
        DPSM_W_IDLE: begin
          if (do_wr) begin
            wst_ff <= DPSM_W_RESP;
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff > `DPSM_OFF_STAT) ? `DPSM_RESP_SLVERR : `DPSM_RESP_OKAY;
          end
        end
        DPSM_W_RESP: begin
          if (i_bready) begin
            wst_ff <= DPSM_W_IDLE;
            bvalid_ff <= 1'b0;
          end
        end
        default: begin
          wst_ff <= DPSM_W_IDLE;
          bvalid_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Only byte lane 0 carries data; the upper lanes have nothing to hold.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      duty_value_ch0_ff <= `DPSM_DUTY_RST;
      duty_value_ch1_ff <= `DPSM_DUTY_RST;
      dir_ff <= `DPSM_DIR_RST;
      gate_ff <= `DPSM_GATE_RST;
    end else if (i_ce && do_wr && wstrb0_ff) begin
      case (awaddr_ff)
        `DPSM_OFF_DUTY0: duty_value_ch0_ff <= wdata_ff[7:0]; // RL1
        `DPSM_OFF_DUTY1: duty_value_ch1_ff <= wdata_ff[7:0]; // RL1
        `DPSM_OFF_DIR: dir_ff <= wdata_ff[`DPSM_PIN_LSB+1:`DPSM_PIN_LSB];
        `DPSM_OFF_GATE: gate_ff <= wdata_ff[`DPSM_PIN_LSB+1:`DPSM_PIN_LSB];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `DPSM_RESP_OKAY;
    case (i_araddr)
      `DPSM_OFF_DUTY0: nxt_rdata[7:0] = duty_value_ch0_ff;
      `DPSM_OFF_DUTY1: nxt_rdata[7:0] = duty_value_ch1_ff;
      `DPSM_OFF_DIR: nxt_rdata[`DPSM_PIN_LSB+1:`DPSM_PIN_LSB] = dir_ff;
      `DPSM_OFF_GATE: nxt_rdata[`DPSM_PIN_LSB+1:`DPSM_PIN_LSB] = gate_ff;
      `DPSM_OFF_STAT: begin
        nxt_rdata[`DPSM_STAT_CNT_LSB+7:`DPSM_STAT_CNT_LSB] = cnt_ff;
        nxt_rdata[`DPSM_STAT_PIN_LSB+1:`DPSM_STAT_PIN_LSB] = pin_in_ff; // RL14
        nxt_rdata[`DPSM_STAT_WAVE_LSB+1:`DPSM_STAT_WAVE_LSB] = wave;
        nxt_rdata[`DPSM_STAT_MODE_BIT] = P_MODE;
      end
      default: nxt_rresp = `DPSM_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_ff <= DPSM_R_IDLE;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `DPSM_RESP_OKAY;
    end else if (i_ce) begin
      case (rst_ff)
        DPSM_R_IDLE: begin
          if (i_arvalid && arready_ff) begin
            rst_ff <= DPSM_R_DATA;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
          end else begin
            arready_ff <= 1'b1;
          end
        end
        DPSM_R_DATA: begin
          if (i_rready) begin
            rst_ff <= DPSM_R_IDLE;
            rvalid_ff <= 1'b0;
          end
        end
        default: begin
          rst_ff <= DPSM_R_IDLE;
          rvalid_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------------
  // One counter serves both channels, so their periods stay aligned.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 8'h00;
    end else if (i_ce) begin
      cnt_ff <= cnt_ff + 8'h01; // RL3 RL4
    end
  end

  // ----------------------------------------------------------------------
  // Channels and pins
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    dpsm_chan u_chan (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_mode(P_MODE), // RL2
      .i_cnt(cnt_ff),
      .i_duty(c == 0 ? duty_value_ch0_ff : duty_value_ch1_ff),
      .o_wave(wave[c])
    );

    // Three stages; a level counts once the last two agree.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        sync1_ff[c] <= 1'b0;
        sync2_ff[c] <= 1'b0;
        sync3_ff[c] <= 1'b0;
        pin_in_ff[c] <= 1'b0;
      end else if (i_ce) begin
        sync1_ff[c] <= i_pin_in[c];
        sync2_ff[c] <= sync1_ff[c];
        sync3_ff[c] <= sync2_ff[c];
        if (sync2_ff[c] == sync3_ff[c]) begin
          pin_in_ff[c] <= sync3_ff[c];
        end
      end
    end

    // Without the modulator option the gate bit is plain port data.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pin_ff[c] <= '0;
      end else if (i_ce) begin
        pin_ff[c].oe <= !dir_ff[c]; // RL11 RL14
        pin_ff[c].out <= P_PWM_SEL[c] ? (gate_ff[c] && wave[c]) : gate_ff[c]; // RL12 RL13
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_awready = awready_ff;
  assign o_wready = wready_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = arready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_pin = pin_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n || !i_ce);

  property p_wrap;
    cnt_ff == `DPSM_CNT_LAST |=> cnt_ff == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) // RL4
    else $error("Period counter did not wrap after 256 clocks.");

  property p_step;
    i_ce |=> cnt_ff == $past(cnt_ff) + 8'h01;
  endproperty
  a_step: assert property (p_step) // RL3
    else $error("Period counter skipped or stalled.");

  property p_duty_wr;
    do_wr && wstrb0_ff && awaddr_ff == `DPSM_OFF_DUTY0
      |=> duty_value_ch0_ff == $past(wdata_ff[7:0]) && bvalid_ff;
  endproperty
  a_duty_wr: assert property (p_duty_wr) // RL1
    else $error("Duty write did not land.");

  property p_input_dir;
    dir_ff[0] ##1 dir_ff[0] |-> !pin_ff[0].oe;
  endproperty
  a_input_dir: assert property (p_input_dir) // RL14
    else $error("Pin driven while set as input.");

  property p_gate_low;
    !gate_ff[0] ##1 !gate_ff[0] |-> !pin_ff[0].out;
  endproperty
  a_gate_low: assert property (p_gate_low) // RL13
    else $error("Pin not low with the gate closed.");

  property p_gate_pass;
    P_PWM_SEL[0] && gate_ff[0] && !dir_ff[0]
      |=> pin_ff[0].out == $past(wave[0]) && pin_ff[0].oe;
  endproperty
  a_gate_pass: assert property (p_gate_pass) // RL11 RL12
    else $error("Waveform did not reach the pin.");

  c_write: cover property (bvalid_ff && i_bready);
  c_read: cover property (rvalid_ff && i_rready);
  c_pin_pulse: cover property ($rose(pin_ff[0].out));

endmodule : dpsm_top
`default_nettype wire

// [sim/dpsm_load.sv]
/*
 * Far-side model: a plain level load on the two shared pins, with pull-high.
 * Assumes the device drives a pin only while its enable is high.
 */
`timescale 1ns/1ps
`default_nettype none

module dpsm_load
  import dpsm_pkg::*;
(
  // Pins from the device
  input wire dpsm_pin_t [1:0] i_pin,
  // Levels seen on the wires
  output logic [1:0] o_level
);
  // A released pin rises to its pull-high instead of keeping an old level.
  assign o_level[0] = i_pin[0].oe ? i_pin[0].out : 1'b1;
  assign o_level[1] = i_pin[1].oe ? i_pin[1].out : 1'b1;
endmodule : dpsm_load

`default_nettype wire

// [sim/tb_dual_pwm_subcycle_modulator.sv]
/*
 * Bench for the dual sub-cycle modulator: bus tasks, waveform and pin checks.
 * Assumes dpsm_top, dpsm_load, the package and the params header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_params.svh"

module tb_dual_pwm_subcycle_modulator
  import dpsm_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, lvl_a, lvl_b;
  dpsm_pin_t [1:0] pin_a, pin_b;
  logic [255:0] sa0, sa1, sb0, sb1;
  logic oe_all;
  int n_mismatch = 0;
  int checks_done = 0;

  initial forever #10 mclk = ~mclk;

  // A second instance in the two-sub-cycle mode shares the bus inputs.
  dpsm_top uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_pin_in(lvl_a), .o_pin(pin_a));
  dpsm_top #(.P_MODE(DPSM_MODE_71)) uut_b (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce),
    .i_awvalid(awvalid), .o_awready(), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(), .i_bready(bready),
    .o_bresp(), .i_arvalid(arvalid), .o_arready(), .i_araddr(araddr), .o_rvalid(),
    .i_rready(rready), .o_rdata(), .o_rresp(), .i_pin_in(lvl_b), .o_pin(pin_b));
  dpsm_load load_a (.i_pin(pin_a), .o_level(lvl_a));
  dpsm_load load_b (.i_pin(pin_b), .o_level(lvl_b));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic lim(input int k);
    if (k >= 50) begin
      n_mismatch++;
      conclude();
    end
  endtask : lim

  task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    lim(k);
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    lim(k);
    @(posedge mclk);
  endtask : rd

  // Expected level at period position n, built straight from the split tables.
  function automatic logic wav(input logic six, input logic [7:0] v, input int n);
    if (six) return (n % 64) < (v[7:2] + ((n / 64) < v[1:0]));
    return (n % 128) < (v[7:1] + ((n / 128) < v[0]));
  endfunction : wav

  // The capture starts at an unknown phase, so any rotation may match.
  function automatic logic rot_ok(input logic [255:0] s, input logic six,
                                  input logic [7:0] v);
    for (int q = 0; q < 256; q++) begin
      int k;
      for (k = 0; k < 256 && s[k] === wav(six, v, (k + q) % 256); k++);
      if (k == 256) return 1'b1;
    end
    return 1'b0;
  endfunction : rot_ok

  task automatic cap();
    oe_all = 1'b1;
    for (int n = 0; n < 256; n++) begin
      @(posedge mclk);
      sa0[n] = pin_a[0].out;
      sa1[n] = pin_a[1].out;
      sb0[n] = pin_b[0].out;
      sb1[n] = pin_b[1].out;
      oe_all = oe_all & pin_a[0].oe & pin_a[1].oe & pin_b[0].oe & pin_b[1].oe;
    end
  endtask : cap

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    rd(5'h00, d, r);
    chk(d, 32'h0);
    rd(5'h08, d, r);
    chk(d, 32'h30);
    chk({30'h0, pin_a[0].oe, pin_a[1].oe}, 32'h0);
    wr(5'h04, 32'hffff_ff66, r);
    rd(5'h04, d, r);
    chk(d, 32'h66);
    rd(5'h14, d, r);
    chk({d[29:0], r}, 32'h2);
    wr(5'h14, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    rd(5'h10, d, r);
    chk({29'h0, d[12], d[9:8]}, 32'h7);
    $display("test reset done");
  endtask : t_reset

  task automatic t_wave();
    logic [7:0] tab [5] = '{8'h00, 8'h01, 8'h66, 8'hff, 8'h81};
    foreach (tab[j]) begin
      wr(5'h00, {24'h0, tab[j]}, r);
      wr(5'h04, {24'h0, ~tab[j]}, r);
      wr(5'h08, 32'h0, r);
      wr(5'h0c, 32'h30, r);
      repeat (600) @(posedge mclk);
      cap();
      chk({31'h0, oe_all}, 32'h1);
      chk({31'h0, rot_ok(sa0, 1'b1, tab[j])}, 32'h1);
      chk({31'h0, rot_ok(sa1, 1'b1, ~tab[j])}, 32'h1);
      chk({31'h0, rot_ok(sb0, 1'b0, tab[j])}, 32'h1);
      chk({31'h0, rot_ok(sb1, 1'b0, ~tab[j])}, 32'h1);
    end
    $display("test wave done");
  endtask : t_wave

  task automatic t_gate();
    wr(5'h0c, 32'h0, r);
    repeat (4) @(posedge mclk);
    cap();
    chk({30'h0, oe_all, |{sa0, sa1, sb0, sb1}}, 32'h2);
    wr(5'h08, 32'h30, r);
    repeat (8) @(posedge mclk);
    chk({28'h0, pin_a[0].oe, pin_b[1].oe, lvl_a}, 32'h3);
    rd(5'h10, d, r);
    chk({30'h0, d[9:8]}, 32'h3);
    wr(5'h0c, 32'h30, r);
    repeat (4) @(posedge mclk);
    chk({30'h0, pin_a[1].oe, pin_b[0].oe}, 32'h0);
    $display("test gate done");
  endtask : t_gate

  // Back-to-back status reads are three edges apart; the frozen edges add nothing.
  task automatic t_freeze();
    logic [7:0] c0;
    rd(5'h10, d, r);
    c0 = d[7:0];
    ce <= 1'b0;
    repeat (10) @(posedge mclk);
    ce <= 1'b1;
    rd(5'h10, d, r);
    chk({24'h0, d[7:0] - c0}, 32'h3);
    $display("test freeze done");
  endtask : t_freeze

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_wave();
    t_gate();
    t_freeze();
    conclude();
  end
endmodule : tb_dual_pwm_subcycle_modulator

`default_nettype wire
